/* File: hw/tmr_pkg.sv */
// Constants shared by the 8-bit timer channel and its prescaler.
package tmr_pkg;

  // ****************************************************************
  // Register bus geometry and register indices
  // ****************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COMPARE = 3'h1;
  localparam logic [2:0] ADDR_DUTY = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  localparam logic [2:0] ADDR_COUNT = 3'h5;

  // ****************************************************************
  // Control register fields, reset values and count limits
  // ****************************************************************
  localparam int CTRL_FLOP_BIT = 7;
  localparam int CTRL_CLK_LSB = 4;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'hff;
  localparam logic [7:0] DUTY_RESET = 8'h80;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  // ****************************************************************
  // Operating modes and clock sources
  // ****************************************************************
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_DIVIDER = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_EVENT = 3'h4;
  localparam logic [2:0] CLK_DIV2048 = 3'h0;
  localparam logic [2:0] CLK_DIV128 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV8 = 3'h3;
  localparam logic [2:0] CLK_SLOW = 3'h4;
  localparam logic [2:0] CLK_DIV2 = 3'h5;
  localparam logic [2:0] CLK_DIV1 = 3'h6;

  // ****************************************************************
  // Prescaler geometry
  // ****************************************************************
  localparam int PRESCALE_W = 11;
  localparam logic [10:0] PRE_MASK_2048 = 11'h7ff;
  localparam logic [10:0] PRE_MASK_128 = 11'h07f;
  localparam logic [10:0] PRE_MASK_32 = 11'h01f;
  localparam logic [10:0] PRE_MASK_8 = 11'h007;
  localparam logic [10:0] PRE_MASK_2 = 11'h001;
  localparam logic [10:0] PRE_MASK_1 = 11'h000;

endpackage

/* File: hw/tmr_prescaler.sv */
// Free-running prescaler that makes the selected source clock tick.
`timescale 1ns/1ps

module tmr_prescaler
  import tmr_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [2:0] clockSel, // Source clock select.
  input wire logic slowClockTick, // One-cycle tick of the slow clock.
  output logic sourceTick // One-cycle tick of the selected source.
);

  logic [PRESCALE_W-1:0] pre_r;
  logic [PRESCALE_W-1:0] selMask;

  function automatic logic [PRESCALE_W-1:0] sel_mask(input logic [2:0] s);
    case (s)
      CLK_DIV2048: sel_mask = PRE_MASK_2048;
      CLK_DIV128: sel_mask = PRE_MASK_128;
      CLK_DIV32: sel_mask = PRE_MASK_32;
      CLK_DIV8: sel_mask = PRE_MASK_8;
      CLK_DIV2: sel_mask = PRE_MASK_2;
      CLK_DIV1: sel_mask = PRE_MASK_1;
      default: sel_mask = PRE_MASK_2048;
    endcase
  endfunction

  assign selMask = sel_mask(clockSel);
  // The divide-by-one source ticks every cycle since its mask is empty.
  assign sourceTick = (clockSel == CLK_SLOW) ? slowClockTick :
                      ((pre_r & selMask) == selMask);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

endmodule // tmr_prescaler

/* File: hw/tmr_channel.sv */
// One 8-bit timer channel: event counter, divider output and PWM output.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps

// How it works
// - Event mode counts falling edges of input.
// - Event match raises interrupt, clears counter.
// - Compare register takes effect immediately, unbuffered.
// - Divider match toggles flop, clears, interrupts.
// - Divider pin is inverse of flop.
// - Flop loadable by control bit, reset clears.
// - Bit 3 runs, bit 7 loads flop.
// - Control 0x11 selects divider; 0x19 starts.
// - PWM toggles on duty match and overflow.
// - PWM pin is inverse of flop.
// - Duty buffered until overflow, direct when stopped.
// - Duty reads return the active value.
module tmr_channel
  import tmr_pkg::*;
(
  input wire logic clk_sys, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] regAddr, // Register index.
  input wire logic [DATA_W-1:0] regWdata, // Write data.
  input wire logic regWe, // Write strobe.
  input wire logic regRe, // Read strobe.
  output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe.
  input wire logic eventInputPin, // External event input.
  input wire logic slowClockTick, // Slow clock tick from the system.
  output logic dividerOutputPin, // Divider output, inverted flop.
  output logic pwmOutputPin, // PWM output, inverted flop.
  output logic channelMatchIrq // Level interrupt.
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl_r;
  logic [7:0] compare_r;
  logic [7:0] dutyBuf_r;
  logic [7:0] dutyAct_r;
  logic [7:0] dutyAct_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic flop_r;
  logic flop_nxt;
  logic status_r;
  logic status_nxt;
  logic mask_r;
  logic evtPrev_r;
  logic [DATA_W-1:0] rdata_r;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  logic runBit;
  logic [2:0] mode;
  logic [2:0] clockSel;
  logic modeEvent;
  logic modeDivider;
  logic modePwm;
  logic srcTick;
  logic evtFall;
  logic step;
  logic [7:0] cntInc;
  logic cmpHit;
  logic pwmWrap;
  logic pwmDutyHit;
  logic matchEvt;
  logic flopToggle;
  logic ctrlWrite;
  logic compareWrite;
  logic dutyWrite;
  logic statusWrite;
  logic maskWrite;
  logic [DATA_W-1:0] readMux;

  function automatic logic is_write(input logic we,
                                    input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] target);
    is_write = we && (a == target);
  endfunction

  assign runBit = ctrl_r[CTRL_RUN_BIT];
  assign mode = ctrl_r[CTRL_MODE_LSB +: 3];
  assign clockSel = ctrl_r[CTRL_CLK_LSB +: 3];
  assign modeEvent = (mode == MODE_EVENT);
  assign modeDivider = (mode == MODE_DIVIDER);
  assign modePwm = (mode == MODE_PWM);

  assign ctrlWrite = is_write(regWe, regAddr, ADDR_CTRL);
  assign compareWrite = is_write(regWe, regAddr, ADDR_COMPARE);
  assign dutyWrite = is_write(regWe, regAddr, ADDR_DUTY);
  assign statusWrite = is_write(regWe, regAddr, ADDR_STATUS);
  assign maskWrite = is_write(regWe, regAddr, ADDR_MASK);

  tmr_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clockSel(clockSel),
    .slowClockTick(slowClockTick),
    .sourceTick(srcTick)
  );

  // The pin is taken as synchronous; the source must hold each level for
  // two cycles, so one history flop is enough to see every falling edge.
  assign evtFall = evtPrev_r && !eventInputPin;
  assign step = runBit && (modeEvent ? evtFall : srcTick);
  assign cntInc = cnt_r + COUNT_STEP;

  // Compare is read straight from the register, so a write acts at once.
  assign cmpHit = step && !modePwm && (cntInc == compare_r);
  assign pwmWrap = step && modePwm && (cnt_r == COUNT_MAX);
  assign pwmDutyHit = step && modePwm && !pwmWrap &&
                      (cntInc == dutyAct_r);
  assign matchEvt = cmpHit || pwmWrap;
  assign flopToggle = (cmpHit && modeDivider) || pwmWrap ||
                      pwmDutyHit;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    if (!runBit)
      cnt_nxt = '0;
    else if (matchEvt)
      cnt_nxt = '0;
    else if (step)
      cnt_nxt = cntInc;
    else
      cnt_nxt = cnt_r;
  end

  // The flop loads only when the timer was already stopped, so the write
  // that stops it keeps the pin level and a later write sets it.
  always_comb
  begin
    if (ctrlWrite && !runBit)
      flop_nxt = regWdata[CTRL_FLOP_BIT];
    else if (flopToggle && runBit)
      flop_nxt = !flop_r;
    else
      flop_nxt = flop_r;
  end

  always_comb
  begin
    if (dutyWrite && !runBit)
      dutyAct_nxt = regWdata;
    else if (pwmWrap)
      dutyAct_nxt = dutyBuf_r;
    else
      dutyAct_nxt = dutyAct_r;
  end

  // A match in the clearing cycle is kept: the set wins.
  assign status_nxt = (status_r && !(statusWrite && regWdata[0])) ||
                      matchEvt;

  assign readMux = (regAddr == ADDR_CTRL) ? ctrl_r :
                   (regAddr == ADDR_COMPARE) ? compare_r :
                   (regAddr == ADDR_DUTY) ? dutyAct_r :
                   (regAddr == ADDR_STATUS) ? {6'h00, flop_r, status_r} :
                   (regAddr == ADDR_MASK) ? {7'h00, mask_r} :
                   (regAddr == ADDR_COUNT) ? cnt_r : 8'h00;

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RESET;
      compare_r <= COMPARE_RESET;
      dutyBuf_r <= DUTY_RESET;
      dutyAct_r <= DUTY_RESET;
      cnt_r <= '0;
      flop_r <= 1'b0;
      status_r <= 1'b0;
      mask_r <= 1'b0;
      evtPrev_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      if (ctrlWrite)
        ctrl_r <= regWdata;
      if (compareWrite)
        compare_r <= regWdata;
      if (dutyWrite)
        dutyBuf_r <= regWdata;
      if (maskWrite)
        mask_r <= regWdata[0];
      dutyAct_r <= dutyAct_nxt;
      cnt_r <= cnt_nxt;
      flop_r <= flop_nxt;
      status_r <= status_nxt;
      evtPrev_r <= eventInputPin;
      rdata_r <= regRe ? readMux : '0;
    end
  end

  assign regRdata = rdata_r;
  assign dividerOutputPin = !flop_r;
  assign pwmOutputPin = !flop_r;
  assign channelMatchIrq = status_r && mask_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Software leaves idle bus cycles between two control writes, so each
  // pair is matched within a short window instead of back to back.
  sequence s_ctrl_start_div;
    ctrlWrite && regWdata == 8'h11 ##[1:8] ctrlWrite && regWdata == 8'h19;
  endsequence

  sequence s_stop_then_clear;
    ctrlWrite && !regWdata[CTRL_RUN_BIT]
    ##[1:8] ctrlWrite && !runBit && !regWdata[CTRL_RUN_BIT] &&
    !regWdata[CTRL_FLOP_BIT];
  endsequence

  a_event_step: assert property (
    runBit && modeEvent && evtFall && cntInc != compare_r && !ctrlWrite
    |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("event edge did not step the counter");

  a_event_match: assert property (
    runBit && modeEvent && evtFall && cntInc == compare_r && !ctrlWrite
    |=> cnt_r == 8'h00 && status_r)
    else $error("event match did not clear and flag");

  a_compare_now: assert property (
    compareWrite |=> compare_r == $past(regWdata))
    else $error("compare write not effective at once");

  a_divider_toggle: assert property (
    runBit && modeDivider && srcTick && cntInc == compare_r && !ctrlWrite
    |=> flop_r != $past(flop_r) && cnt_r == 8'h00 && status_r)
    else $error("divider match did not toggle");

  a_pins_inverse: assert property (
    $changed(flop_r) |-> $changed(dividerOutputPin) &&
                         dividerOutputPin != flop_r)
    else $error("divider pin not inverse of flop");

  a_flop_load: assert property (
    ctrlWrite && !runBit |=> flop_r == $past(regWdata[CTRL_FLOP_BIT]))
    else $error("flop not loaded while stopped");

  a_stop_hold: assert property (
    !runBit && !ctrlWrite ##1 !runBit && !ctrlWrite |-> $stable(flop_r))
    else $error("flop moved while stopped");

  a_stop_pin_high: assert property (
    s_stop_then_clear |=> dividerOutputPin && pwmOutputPin)
    else $error("stop then clear did not drive pin high");

  a_ctrl_start: assert property (
    s_ctrl_start_div |=> runBit && modeDivider &&
                         clockSel == CLK_DIV128)
    else $error("control values did not start divider");

  a_pwm_duty: assert property (
    runBit && modePwm && srcTick && cnt_r != 8'hff &&
    cntInc == dutyAct_r && !ctrlWrite
    |=> flop_r != $past(flop_r) && cnt_r == $past(cnt_r) + 8'h01)
    else $error("duty match did not toggle");

  a_pwm_wrap: assert property (
    runBit && modePwm && srcTick && cnt_r == 8'hff && !ctrlWrite
    |=> cnt_r == 8'h00 && flop_r != $past(flop_r) && status_r)
    else $error("overflow did not wrap");

  a_pwm_pin: assert property (
    $rose(flop_r) |-> $fell(pwmOutputPin))
    else $error("pwm pin not inverse of flop");

  a_duty_buffered: assert property (
    dutyWrite && runBit && !pwmWrap
    |=> dutyAct_r == $past(dutyAct_r) && dutyBuf_r == $past(regWdata))
    else $error("running duty write acted early");

  a_duty_direct: assert property (
    dutyWrite && !runBit |=> dutyAct_r == $past(regWdata))
    else $error("stopped duty write not direct");

  a_duty_read: assert property (
    regRe && regAddr == ADDR_DUTY |=> regRdata == $past(dutyAct_r))
    else $error("duty read not active value");

  a_irq_set_wins: assert property (
    matchEvt && statusWrite && regWdata[0] |=> status_r)
    else $error("match lost against clear");

  a_stopped_zero: assert property (
    !runBit |=> cnt_r == 8'h00)
    else $error("stopped counter not held at zero");

  a_event_hold: assert property (
    runBit && modeEvent && !evtFall |=> $stable(cnt_r))
    else $error("event counter moved without an edge");

  a_divider_step: assert property (
    runBit && modeDivider && srcTick && cntInc != compare_r
    |=> cnt_r == $past(cnt_r) + 8'h01 && $stable(flop_r))
    else $error("divider step wrong");

  a_run_write_flop: assert property (
    ctrlWrite && runBit && !flopToggle |=> $stable(flop_r))
    else $error("write while running moved the flop");

  a_status_sticky: assert property (
    status_r && !(statusWrite && regWdata[0]) |=> status_r)
    else $error("status bit dropped without a clear");

  a_status_clear: assert property (
    statusWrite && regWdata[0] && !matchEvt |=> !status_r)
    else $error("status clear did not act");

  a_irq_follows: assert property (
    matchEvt && mask_r && !maskWrite |=> channelMatchIrq)
    else $error("unmasked match gave no interrupt");

  a_read_idle: assert property (
    !regRe |=> regRdata == 8'h00)
    else $error("read data not zero outside a read");

  a_pwm_hold: assert property (
    runBit && modePwm && !srcTick |=> $stable(cnt_r) && $stable(flop_r))
    else $error("pwm moved without a source tick");

  a_wrap_loads_duty: assert property (
    pwmWrap |=> dutyAct_r == $past(dutyBuf_r))
    else $error("wrap did not load buffered duty");

endmodule // tmr_channel

/* File: bench/tmr_event_source.sv */
// Behavioural pulse source that drives the channel's event input pin.
`timescale 1ns/1ps

module tmr_event_source
(
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic startReq, // One-cycle burst request.
  input wire logic [3:0] pulseCount, // Falling edges per burst.
  output logic eventInputPin, // Event line, idles high.
  output logic busy // High while a burst runs.
);
  logic [4:0] togglesLeft_r;
  logic [1:0] hold_r;

  assign busy = (togglesLeft_r != 5'h00);

  // Each level stands three cycles, one more than the minimum, so the
  // channel's edge detector never sees a level shorter than allowed.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      togglesLeft_r <= 5'h00;
      hold_r <= 2'h0;
      eventInputPin <= 1'b1;
    end
    else if (startReq)
    begin
      togglesLeft_r <= {pulseCount, 1'b0};
      hold_r <= 2'h0;
    end
    else if (busy)
    begin
      if (hold_r == 2'h2)
      begin
        hold_r <= 2'h0;
        eventInputPin <= ~eventInputPin;
        togglesLeft_r <= togglesLeft_r - 5'h01;
      end
      else
        hold_r <= hold_r + 2'h1;
    end
  end
endmodule // tmr_event_source

/* File: bench/tmr_channel_tb.sv */
// Self-checking testbench for the 8-bit timer channel.
`timescale 1ns/1ps

module tmr_channel_tb
  import tmr_pkg::*;
;
  logic clk_sys, rst_n, regWe, regRe, startReq, srcBusy;
  logic slowClockTick = 1'b0;
  logic portLatch = 1'b0;
  logic divSeen, pwmSeen;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic [3:0] pulseCount;
  logic [1:0] slowDiv_r = 2'h0;
  logic eventInputPin, dividerOutputPin, pwmOutputPin, channelMatchIrq, p;
  int bad_count, compares, n;
  logic [7:0] rstVal [7] = '{8'h00, 8'hff, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};

  tmr_channel DUT (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWe(regWe), .regRe(regRe), .regRdata(regRdata),
    .eventInputPin(eventInputPin), .slowClockTick(slowClockTick),
    .dividerOutputPin(dividerOutputPin), .pwmOutputPin(pwmOutputPin),
    .channelMatchIrq(channelMatchIrq));

  // The port latch gates what the pins show to the outside world.
  assign divSeen = dividerOutputPin & portLatch;
  assign pwmSeen = pwmOutputPin & portLatch;

  tmr_event_source src (.clk_sys(clk_sys), .rst_n(rst_n),
    .startReq(startReq), .pulseCount(pulseCount),
    .eventInputPin(eventInputPin), .busy(srcBusy));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    slowDiv_r <= slowDiv_r + 2'h1;
    slowClockTick <= (slowDiv_r == 2'h3);
  end

  // ****************************************************************
  // Bus, compare and wait tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkCount(input int got, input int exp, input string what);
    compares++;
    if (got != exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge clk_sys);
    regWe <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is
  // sampled just after the edge that takes the strobe.
  task automatic rdReg(input logic [2:0] a, input logic [7:0] exp,
                       input string what);
    @(posedge clk_sys);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge clk_sys);
    regRe <= 1'b0;
    #1;
    chkByte(regRdata, exp, what);
  endtask

  task automatic burst(input logic [3:0] k);
    int i;
    @(posedge clk_sys);
    pulseCount <= k;
    startReq <= 1'b1;
    @(posedge clk_sys);
    startReq <= 1'b0;
    #1;
    for (i = 0; i < 200 && srcBusy !== 1'b0; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    if (srcBusy !== 1'b0)
    begin
      bad_count++;
      $display("MISMATCH t=%0t event burst hung", $time);
      end_of_test();
    end
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic waitPin(input bit pwm, input logic lvl, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while ((pwm ? pwmSeen : divSeen) !== lvl && cnt < 600);
    if ((pwm ? pwmSeen : divSeen) !== lvl)
    begin
      bad_count++;
      $display("MISMATCH t=%0t output pin wait timed out", $time);
      end_of_test();
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {regWe, regRe, startReq, regAddr, regWdata, pulseCount} = '0;
    bad_count = 0;
    compares = 0;
    doReset();
    for (int i = 0; i < 7; i++)
      rdReg(i[2:0], rstVal[i], "reset value");
    chkByte({6'h0, dividerOutputPin, pwmOutputPin}, 8'h03, "reset pins");
    wrReg(ADDR_COUNT, 8'h55);
    rdReg(ADDR_COUNT, 8'h00, "count read-only");
    wrReg(3'h6, 8'h55);
    rdReg(3'h6, 8'h00, "unmapped read");
    // Event counting with the flop bit kept at zero.
    wrReg(ADDR_COMPARE, 8'h03);
    wrReg(ADDR_MASK, 8'h01);
    wrReg(ADDR_CTRL, 8'h0c);
    burst(4'h2);
    rdReg(ADDR_COUNT, 8'h02, "event count");
    burst(4'h1);
    rdReg(ADDR_COUNT, 8'h00, "event clear");
    rdReg(ADDR_STATUS, 8'h01, "event status");
    chkByte({7'h0, channelMatchIrq}, 8'h01, "event irq");
    wrReg(ADDR_STATUS, 8'h01);
    rdReg(ADDR_STATUS, 8'h00, "status cleared");
    chkByte({7'h0, channelMatchIrq}, 8'h00, "irq cleared");
    wrReg(ADDR_MASK, 8'h00);
    wrReg(ADDR_COMPARE, 8'h01);
    burst(4'h1);
    rdReg(ADDR_STATUS, 8'h01, "compare unbuffered");
    chkByte({7'h0, channelMatchIrq}, 8'h00, "masked irq");
    chkByte({6'h0, dividerOutputPin, pwmOutputPin}, 8'h03, "event pins");
    wrReg(ADDR_STATUS, 8'h01);
    wrReg(ADDR_MASK, 8'h01);
    portLatch = 1'b1;
    // Divider output at the full system rate.
    wrReg(ADDR_CTRL, 8'h11);
    rdReg(ADDR_CTRL, 8'h11, "divider stopped");
    rdReg(ADDR_COUNT, 8'h00, "stopped count");
    wrReg(ADDR_CTRL, 8'h19);
    rdReg(ADDR_CTRL, 8'h19, "divider started");
    wrReg(ADDR_CTRL, 8'h61);
    wrReg(ADDR_COMPARE, 8'h02);
    wrReg(ADDR_CTRL, 8'h69);
    waitPin(1'b0, 1'b0, n);
    waitPin(1'b0, 1'b1, n);
    chkCount(n, 2, "divider high half");
    waitPin(1'b0, 1'b0, n);
    chkCount(n, 2, "divider low half");
    chkByte({7'h0, channelMatchIrq}, 8'h01, "divider irq");
    // Slow clock and divide-by-eight sources, restarted from a known flop.
    wrReg(ADDR_CTRL, 8'h41);
    wrReg(ADDR_CTRL, 8'h49);
    waitPin(1'b0, 1'b0, n);
    waitPin(1'b0, 1'b1, n);
    chkCount(n, 8, "slow source half");
    wrReg(ADDR_CTRL, 8'h31);
    wrReg(ADDR_CTRL, 8'h39);
    waitPin(1'b0, 1'b0, n);
    waitPin(1'b0, 1'b1, n);
    chkCount(n, 16, "div8 source half");
    wrReg(ADDR_CTRL, 8'h61);
    #1;
    p = dividerOutputPin;
    repeat (6) @(posedge clk_sys);
    #1;
    chkByte({7'h0, dividerOutputPin}, {7'h0, p}, "stop holds pin");
    chkByte({7'h0, pwmOutputPin}, {7'h0, p}, "pwm pin tracks flop");
    wrReg(ADDR_STATUS, 8'h01);
    wrReg(ADDR_CTRL, 8'he1);
    rdReg(ADDR_STATUS, 8'h02, "flop loaded");
    chkByte({7'h0, dividerOutputPin}, 8'h00, "pin low");
    wrReg(ADDR_CTRL, 8'h61);
    rdReg(ADDR_STATUS, 8'h00, "flop cleared");
    chkByte({7'h0, dividerOutputPin}, 8'h01, "pin high");
    wrReg(ADDR_CTRL, 8'he1);
    doReset();
    #1;
    chkByte({6'h0, dividerOutputPin, pwmOutputPin}, 8'h03, "reset flop");
    // PWM with a duty change taken at the wrap.
    wrReg(ADDR_DUTY, 8'h40);
    rdReg(ADDR_DUTY, 8'h40, "duty direct");
    wrReg(ADDR_CTRL, 8'h6a);
    waitPin(1'b1, 1'b0, n);
    waitPin(1'b1, 1'b1, n);
    chkCount(n, 192, "pwm low time");
    wrReg(ADDR_DUTY, 8'h80);
    rdReg(ADDR_DUTY, 8'h40, "duty still active");
    waitPin(1'b1, 1'b0, n);
    waitPin(1'b1, 1'b1, n);
    chkCount(n, 192, "old duty kept");
    rdReg(ADDR_DUTY, 8'h80, "duty after wrap");
    waitPin(1'b1, 1'b0, n);
    waitPin(1'b1, 1'b1, n);
    chkCount(n, 128, "new duty low");
    waitPin(1'b1, 1'b0, n);
    chkCount(n, 128, "pwm high time");
    rdReg(ADDR_STATUS, 8'h03, "pwm status");
    wrReg(ADDR_CTRL, 8'h62);
    repeat (4) @(posedge clk_sys);
    #1;
    chkByte({7'h0, pwmOutputPin}, 8'h00, "pwm stop holds");
    end_of_test();
  end
endmodule // tmr_channel_tb
